// *** rtl/drf_pkg.sv ***
// Constants, register map and state type of the DRAM refresh block
// What this block does
// - Refresh requests happen only in enhanced mode, never in compatible mode.
// - Each elapsed interval raises a memory read request to the bus interface unit.
// - A matching chip select is asserted and its ready and wait states apply.
// - With no chip select hit, the cycle ends only on external ready.
// - A pending refresh withdraws the bus grant even while hold stays requested.
// - Refresh registers are accessible in enhanced mode; reserved fields read zero.
// - In compatible mode writes do nothing and reads return no valid data.
// - Partition bits 15..9 form address bits 19..13; bits 8..0 read zero.
// - Address bits 9..1 are the row counter, 12..10 zero, bit 0 one.
// - The row counter steps as a linear feedback shift register.
// - Reset clears the partition field.
// - Writing the enable bit set starts the unit and loads countdown from prescale.
// - The countdown decrements once per processor output clock.
// - At countdown one a refresh is requested and the countdown reloads.
// - Clearing enable zeroes the countdown, stops requests, keeps the row counter.
// - Power-save division slows the refresh clock by the division factor.
// - Enhanced mode follows an attached coprocessor or reset output loopback.
package drf_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_PARTITION = 8'hE0;
  localparam logic [7:0]  IDX_PRESCALE  = 8'hE2;
  localparam logic [7:0]  IDX_ENABLE    = 8'hE4;
  localparam logic [7:0]  IDX_POWER_DIV = 8'hF0;
  localparam int          ADDR_W        = 12;

  // Field layout
  localparam int          PART_LSB      = 9;
  localparam int          PART_W        = 7;
  localparam int          PRE_W         = 9;
  localparam int          ENABLE_BIT    = 15;
  localparam int          PD_ENABLE_BIT = 15;
  localparam int          PD_SEL_W      = 2;
  localparam int          ZERO_HI_W     = 3;
  localparam int          WS_W          = 4;

  // Reset values and counter constants
  localparam logic [6:0]  PARTITION_RST = 7'h00;
  localparam logic [8:0]  PRESCALE_RST  = 9'h000;
  localparam logic [8:0]  COUNT_CLEAR   = 9'h000;
  localparam logic [8:0]  COUNT_FIRE    = 9'h001;
  localparam logic [8:0]  ROW_SEED      = 9'h001;
  localparam int          LFSR_TAP      = 4;

  // Power-save divide masks for select 0..3 (divide by 1, 4, 8, 16)
  localparam logic [3:0]  DIV_MASK_0    = 4'h0;
  localparam logic [3:0]  DIV_MASK_1    = 4'h3;
  localparam logic [3:0]  DIV_MASK_2    = 4'h7;
  localparam logic [3:0]  DIV_MASK_3    = 4'hF;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b001,
    ST_WAITST = 3'b010,
    ST_READY  = 3'b100
  } drf_state_t;

endpackage

// *** rtl/drf_top.sv ***
// DRAM refresh control block with APB register slave
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module drf_top
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode pins
  input  wire logic        coproc_present,
  input  wire logic        reset_loopback,
  // Bus hold
  input  wire logic        hold_req,
  output logic             bus_grant_out,
  // Bus interface unit
  output logic             refresh_req,
  output logic      [19:0] refresh_addr,
  input  wire logic        biu_refresh_start,
  output logic             refresh_done,
  // Chip select and ready
  input  wire logic        cs_hit,
  input  wire logic        cs_use_ready,
  input  wire logic [3:0]  cs_wait_states,
  output logic             refresh_cs_en,
  input  wire logic        ext_ready
);

  // Address match of one register index
  function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction

  // Divide mask from power-save select
  function automatic logic [3:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'b00:   return drf_pkg::DIV_MASK_0;
      2'b01:   return drf_pkg::DIV_MASK_1;
      2'b10:   return drf_pkg::DIV_MASK_2;
      default: return drf_pkg::DIV_MASK_3;
    endcase
  endfunction

  // Next row counter value
  function automatic logic [8:0] lfsr_next(input logic [8:0] r);
    return {r[7:0], r[8] ^ r[drf_pkg::LFSR_TAP]};
  endfunction

  logic [3:0]  meta_ff;
  logic [3:0]  sync_ff;
  logic [6:0]  part_ff;
  logic [8:0]  pre_ff;
  logic        en_ff;
  logic        pd_en_ff;
  logic [1:0]  pd_sel_ff;
  logic [3:0]  div_cnt_ff;
  logic [8:0]  cnt_ff;
  logic [8:0]  row_ff;
  logic        pending_ff;
  logic        grant_ff;
  logic        cs_sel_ff;
  logic        cs_rdy_ff;
  logic [3:0]  ws_ff;
  logic        done_ff;
  logic [31:0] prdata_ff;
  drf_pkg::drf_state_t state_ff;
  drf_pkg::drf_state_t nxt_state;

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
    end
    else if (ce)
    begin
      meta_ff <= {ext_ready, hold_req, reset_loopback, coproc_present};
      sync_ff <= meta_ff;
    end
  end

  // Enhanced mode from coprocessor or reset loopback
  // mode selection
  wire enhanced = sync_ff[0] | sync_ff[1];
  wire hold_s   = sync_ff[2];
  wire rdy_s    = sync_ff[3];

  // APB decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire hit_part = reg_hit(paddr, drf_pkg::IDX_PARTITION);
  wire hit_pre  = reg_hit(paddr, drf_pkg::IDX_PRESCALE);
  wire hit_en   = reg_hit(paddr, drf_pkg::IDX_ENABLE);
  wire hit_pd   = reg_hit(paddr, drf_pkg::IDX_POWER_DIV);
  wire mapped   = hit_part | hit_pre | hit_en | hit_pd;
  wire wr_ok    = access & pwrite & enhanced & ce;
  wire wr_part  = wr_ok & hit_part;
  wire wr_pre   = wr_ok & hit_pre;
  wire wr_en    = wr_ok & hit_en;
  wire wr_pd    = wr_ok & hit_pd;
  wire en_bit   = pwdata[drf_pkg::ENABLE_BIT];

  assign pready  = ce;
  assign pslverr = access & ~(mapped & enhanced);

  // Read mux, reserved bits read zero
  // partition readback
  wire [31:0] rd_part = {16'h0000, part_ff, 9'h000};
  wire [31:0] rd_pre  = {23'h000000, pre_ff};
  wire [31:0] rd_en   = {16'h0000, en_ff, 6'h00, cnt_ff};
  wire [31:0] rd_pd   = {16'h0000, pd_en_ff, 13'h0000, pd_sel_ff};
  wire [31:0] rd_mux  = hit_part ? rd_part :
                        hit_pre  ? rd_pre  :
                        hit_en   ? rd_en   :
                        hit_pd   ? rd_pd   : 32'h00000000;

  // no valid data in compatible mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h00000000;
    else if (ce && setup)
      prdata_ff <= (enhanced && !pwrite) ? rd_mux : 32'h00000000;
  end
  assign prdata = prdata_ff;

  // Configuration registers
  // partition cleared on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      part_ff   <= drf_pkg::PARTITION_RST;
      pre_ff    <= drf_pkg::PRESCALE_RST;
      en_ff     <= 1'b0;
      pd_en_ff  <= 1'b0;
      pd_sel_ff <= 2'b00;
    end
    else if (ce)
    begin
      if (wr_part)
        part_ff <= pwdata[drf_pkg::PART_LSB +: drf_pkg::PART_W];
      if (wr_pre)
        pre_ff <= pwdata[drf_pkg::PRE_W-1:0];
      if (wr_en)
        en_ff <= en_bit;
      if (wr_pd)
      begin
        pd_en_ff  <= pwdata[drf_pkg::PD_ENABLE_BIT];
        pd_sel_ff <= pwdata[drf_pkg::PD_SEL_W-1:0];
      end
    end
  end

  // Processor output clock tick, slowed in power-save
  // clock division
  wire [3:0] mask = pd_en_ff ? div_mask(pd_sel_ff) : drf_pkg::DIV_MASK_0;
  wire       tick = (div_cnt_ff & mask) == mask;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_ff <= 4'h0;
    else if (ce)
      div_cnt_ff <= tick ? 4'h0 : div_cnt_ff + 4'h1;
  end

  // Countdown
  // unit idle outside enhanced mode
  wire run  = en_ff & enhanced;
  wire fire = run & tick & (cnt_ff == drf_pkg::COUNT_FIRE) & ~wr_en & ce;
  logic [8:0] nxt_cnt;
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (wr_en && !en_bit)
      nxt_cnt = drf_pkg::COUNT_CLEAR;
    else if (wr_en && en_bit)
      nxt_cnt = pre_ff;
    else if (fire)
      nxt_cnt = pre_ff;
    else if (run && tick)
      nxt_cnt = cnt_ff - 9'h001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= drf_pkg::COUNT_CLEAR;
    else if (ce)
      cnt_ff <= nxt_cnt;
  end

  // Pending request and grant control
  wire idle         = state_ff == drf_pkg::ST_IDLE;
  wire start_accept = biu_refresh_start & refresh_req;
  wire nxt_pending  = fire | (pending_ff & ~start_accept & run);
  wire nxt_grant    = hold_s & ~nxt_pending & idle;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_ff <= 1'b0;
      grant_ff   <= 1'b0;
    end
    else if (ce)
    begin
      pending_ff <= nxt_pending;
      grant_ff   <= nxt_grant;
    end
  end

  // memory read request to bus interface unit
  assign refresh_req   = pending_ff & ~grant_ff & idle & enhanced;
  assign bus_grant_out = grant_ff;

  // Refresh cycle sequencing
  wire ws_zero  = ws_ff == 4'h0;
  wire cyc_done = (state_ff == drf_pkg::ST_WAITST && ws_zero && !cs_rdy_ff) ||
                  (state_ff == drf_pkg::ST_READY && rdy_s);
  always_comb
  begin
    case (state_ff)
      drf_pkg::ST_IDLE:
        nxt_state = !start_accept ? drf_pkg::ST_IDLE :
                    cs_hit ? drf_pkg::ST_WAITST : drf_pkg::ST_READY;
      drf_pkg::ST_WAITST:
        nxt_state = !ws_zero ? drf_pkg::ST_WAITST :
                    cs_rdy_ff ? drf_pkg::ST_READY : drf_pkg::ST_IDLE;
      drf_pkg::ST_READY:
        nxt_state = rdy_s ? drf_pkg::ST_IDLE : drf_pkg::ST_READY;
      default:
        nxt_state = drf_pkg::ST_IDLE;
    endcase
  end

  // chip select, its ready mode and wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff  <= drf_pkg::ST_IDLE;
      cs_sel_ff <= 1'b0;
      cs_rdy_ff <= 1'b0;
      ws_ff     <= 4'h0;
      done_ff   <= 1'b0;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      done_ff  <= cyc_done;
      if (start_accept)
      begin
        cs_sel_ff <= cs_hit;
        cs_rdy_ff <= cs_use_ready;
        ws_ff     <= cs_wait_states;
      end
      else if (state_ff == drf_pkg::ST_WAITST && !ws_zero)
        ws_ff <= ws_ff - 4'h1;
      else if (cyc_done)
        cs_sel_ff <= 1'b0;
    end
  end

  assign refresh_cs_en = cs_sel_ff & ~idle;
  assign refresh_done  = done_ff;

  // Row counter
  // LFSR stepping after each refresh
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      row_ff <= drf_pkg::ROW_SEED;
    else if (ce && cyc_done)
      row_ff <= lfsr_next(row_ff);
  end

  assign refresh_addr = {part_ff, {drf_pkg::ZERO_HI_W{1'b0}}, row_ff, 1'b1};

  // Checks
  sequence s_fire;
    fire;
  endsequence

  sequence s_pending_next;
    ##1 pending_ff;
  endsequence

  a_no_req_compat: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !enhanced) |=> !pending_ff && !refresh_req)
    else $error("refresh request in compatible mode");

  a_fire_pending: assert property (@(posedge pclk) disable iff (!presetn)
    s_fire |-> s_pending_next ##0 (cnt_ff == $past(pre_ff)))
    else $error("countdown at one did not request and reload");

  a_grant_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && grant_ff) |=> !grant_ff && pending_ff)
    else $error("grant kept while refresh pending");

  a_enable_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && !en_bit && idle && !cyc_done) |=> (cnt_ff == drf_pkg::COUNT_CLEAR) && $stable(row_ff))
    else $error("enable clear did not stop countdown");

  a_enable_load: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && en_bit) |=> cnt_ff == $past(pre_ff))
    else $error("countdown not loaded from prescale");

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && run && tick && !wr_en && cnt_ff > drf_pkg::COUNT_FIRE) |=> cnt_ff == $past(cnt_ff) - 9'h001)
    else $error("countdown did not decrement");

  a_addr_layout: assert property (@(posedge pclk) disable iff (!presetn)
    refresh_addr[0] && refresh_addr[12:10] == 3'b000 && refresh_addr[19:13] == part_ff)
    else $error("refresh address layout wrong");

  a_row_lfsr: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cyc_done) |=> row_ff == lfsr_next($past(row_ff)) ##0 done_ff)
    else $error("row counter did not step");

  a_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == drf_pkg::ST_READY && !rdy_s) |=> state_ff == drf_pkg::ST_READY || !$past(ce))
    else $error("cycle ended without external ready");

  a_compat_write: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && access && pwrite && !enhanced) |=> $stable(part_ff) && $stable(pre_ff) && $stable(en_ff))
    else $error("compatible-mode write took effect");

  a_start_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && start_accept && !fire) |=> !pending_ff && (state_ff != drf_pkg::ST_IDLE))
    else $error("start did not clear pending request");

endmodule
`default_nettype wire

// *** testbench/drf_partner.sv ***
// Bus unit, bus hold requester and ready source facing the refresh block
`timescale 1ns/100ps
`default_nettype none
module drf_partner
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Refresh handshake
  input  wire logic       refresh_req,
  input  wire logic       bus_grant_out,
  output logic            biu_refresh_start,
  output logic            ext_ready,
  output logic            hold_req,
  // Scenario control
  input  wire logic       want_hold,
  input  wire logic [1:0] start_dly
);
  logic [1:0] wait_ff;
  logic [3:0] rdy_ff;
  logic [1:0] drop_ff;
  logic       gnt_ff;
  assign hold_req = want_hold && (drop_ff == 2'h0);
  // ready only late in the cycle
  assign ext_ready = (rdy_ff != 4'h0) && (rdy_ff <= 4'h4);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wait_ff <= 2'h0;
    else if (!refresh_req || biu_refresh_start)
      wait_ff <= 2'h0;
    else if (wait_ff != 2'h3)
      wait_ff <= wait_ff + 2'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      biu_refresh_start <= 1'b0;
    else
      biu_refresh_start <= refresh_req && !biu_refresh_start && (wait_ff >= start_dly);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdy_ff <= 4'h0;
    else if (biu_refresh_start && refresh_req)
      rdy_ff <= 4'h8;
    else if (rdy_ff != 4'h0)
      rdy_ff <= rdy_ff - 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gnt_ff <= 1'b0;
      drop_ff <= 2'h0;
    end
    else
    begin
      gnt_ff <= bus_grant_out;
      drop_ff <= (gnt_ff && !bus_grant_out) ? 2'h2 : (drop_ff != 2'h0) ? drop_ff - 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/drf_top_bench.sv ***
// Self-checking bench for the DRAM refresh block
`timescale 1ns/100ps
`default_nettype none
module drf_top_bench;
  logic        pclk, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic        pready, pslverr, err, hold_req, grant, rreq, start, done, cs_en, ext_ready;
  logic        coproc = 1'b0, loopb = 1'b0, cs_hit = 1'b0, cs_use = 1'b0, want_hold = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  cs_ws = 4'h0;
  logic [1:0]  sdly = 2'h0;
  logic [19:0] raddr, addr0;
  logic [6:0]  part = 7'h00;
  logic [8:0]  prow = 9'h001;
  logic        hit_s, st_q = 1'b0, req_q = 1'b0, gnt_q = 1'b0;
  int          mismatches, total_checks, ncyc, last, per, skip, nreq, nref, ngw, cyc, ws_s, p, n0;

  drf_top dut
  (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coproc_present(coproc), .reset_loopback(loopb),
    .hold_req(hold_req), .bus_grant_out(grant), .refresh_req(rreq), .refresh_addr(raddr),
    .biu_refresh_start(start), .refresh_done(done), .cs_hit(cs_hit),
    .cs_use_ready(cs_use), .cs_wait_states(cs_ws), .refresh_cs_en(cs_en),
    .ext_ready(ext_ready)
  );
  drf_partner far_side
  (
    .pclk(pclk), .presetn(presetn), .refresh_req(rreq), .bus_grant_out(grant),
    .biu_refresh_start(start), .ext_ready(ext_ready), .hold_req(hold_req),
    .want_hold(want_hold), .start_dly(sdly)
  );

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t flag %b expected %b", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cs_hit <= 1'($urandom_range(1, 0));
    cs_use <= 1'($urandom_range(1, 0));
    cs_ws <= 4'($urandom_range(3, 0));
    sdly <= 2'($urandom_range(3, 0));
  end

  always @(posedge pclk)
  begin
    ncyc++;
    cyc++;
    if (rreq && !req_q)
    begin
      nreq++;
      if (skip == 0)
        chk_val(ncyc - last, per);
      else
        skip--;
      last = ncyc;
    end
    if (st_q)
      chk_bit(cs_en, hit_s);
    st_q = start && rreq;
    if (st_q)
    begin
      hit_s = cs_hit;
      ws_s = cs_ws;
      cyc = 0;
    end
    if (done)
    begin
      nref++;
      chk_bit(cyc >= (hit_s ? ws_s + 1 : 6), 1'b1);
      chk_val({12'h000, raddr}, {12'h000, part, 3'b000, raddr[9:1], 1'b1});
      prow = {prow[7:0], prow[8] ^ prow[4]};
      chk_val({23'h000000, raddr[9:1]}, {23'h000000, prow});
    end
    if (gnt_q && !grant && hold_req)
      ngw++;
    req_q = rreq;
    gnt_q = grant;
  end

  initial
  begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict();
  end

  initial
  begin
    void'($urandom(96199));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_val({12'h000, raddr}, 32'h0000_0003);
    for (int m = 0; m < 4; m++)
    begin
      {coproc, loopb} <= 2'(m);
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h380, 32'h0);
      chk_val(rd, {16'h0000, part, 9'h000});
      chk_bit(err, m == 0);
      v = $urandom;
      apb(1'b1, 12'h380, v);
      if (m != 0)
        part = v[15:9];
      apb(1'b0, 12'h380, 32'h0);
      chk_val(rd, {16'h0000, part, 9'h000});
      chk_bit(err, m == 0);
      if (m == 0)
      begin
        apb(1'b1, 12'h388, 32'h0000_0012);
        apb(1'b1, 12'h390, 32'h0000_8000);
        repeat (60) @(posedge pclk);
        chk_val(nreq, 0);
      end
    end
    apb(1'b0, 12'h3FC, 32'h0);
    chk_bit(err, 1'b1);
    $display("mode and register test done");
    p = 18 + $urandom_range(7, 0);
    v = $urandom;
    v[8:0] = 9'(p);
    apb(1'b1, 12'h388, v);
    apb(1'b0, 12'h388, 32'h0);
    chk_val(rd, 32'(p));
    per = p;
    skip = 1;
    // prescale kept at 18 or more
    apb(1'b1, 12'h390, 32'h0000_8000);
    apb(1'b0, 12'h390, 32'h0);
    chk_val(rd, 32'h0000_8000 | 32'(p - 1));
    repeat (6 * p) @(posedge pclk);
    chk_bit(nref >= 4, 1'b1);
    $display("interval test done");
    for (int s = 1; s < 5; s++)
    begin
      skip = 3;
      per = p * ((s == 4) ? 1 : (2 << s));
      apb(1'b1, 12'h3C0, (s == 4) ? 32'h0 : (32'h0000_8000 | 32'(s)));
      repeat (5 * per) @(posedge pclk);
    end
    $display("divide test done");
    skip = 1000;
    n0 = nref;
    want_hold <= 1'b1;
    repeat (5 * p) @(posedge pclk);
    want_hold <= 1'b0;
    chk_bit(ngw > 0, 1'b1);
    chk_bit(nref > n0 + 1, 1'b1);
    $display("hold test done");
    {coproc, loopb} <= 2'b00;
    repeat (20) @(posedge pclk);
    n0 = nreq;
    repeat (4 * p) @(posedge pclk);
    chk_val(nreq, n0);
    {coproc, loopb} <= 2'b11;
    repeat (4) @(posedge pclk);
    $display("compat test done");
    apb(1'b1, 12'h390, 32'h0);
    repeat (20) @(posedge pclk);
    n0 = nreq;
    addr0 = raddr;
    repeat (4 * p) @(posedge pclk);
    chk_val(nreq, n0);
    chk_val({12'h000, raddr}, {12'h000, addr0});
    apb(1'b0, 12'h390, 32'h0);
    chk_val(rd, 32'h0);
    chk_val({23'h000000, raddr[9:1]}, {23'h000000, prow});
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    chk_bit(pready, 1'b0);
    ce <= 1'b1;
    @(posedge pclk);
    $display("disable test done");
    print_verdict();
  end
endmodule
`default_nettype wire
